// [rtl/clkg_consts.svh]
// register offsets, field positions, reset values and timing counts of the clock generator
`ifndef CLKG_CONSTS_SVH
`define CLKG_CONSTS_SVH

`define CLKG_ADDR_CSR        32'h01b7_c100
`define CLKG_ADDR_MULT       32'h01b7_c110
`define CLKG_ADDR_PRE_DIV    32'h01b7_c114
`define CLKG_ADDR_CORE_DIV   32'h01b7_c118
`define CLKG_ADDR_PERIPH_DIV 32'h01b7_c11c
`define CLKG_ADDR_MEM_DIV    32'h01b7_c120
`define CLKG_ADDR_AUX_DIV    32'h01b7_c124

`define CLKG_CSR_SELECT_BIT  0
`define CLKG_CSR_PWRDN_BIT   1
`define CLKG_CSR_RESET_BIT   3
`define CLKG_CSR_STABLE_BIT  6

`define CLKG_DIV_EN_BIT      15
`define CLKG_DIV_RATIO_MSB   4

`define CLKG_MULT_RESET      5'h07
`define CLKG_MULT_MIN        5'h04
`define CLKG_PRE_RATIO_RESET    5'h00
`define CLKG_CORE_RATIO_RESET   5'h00
`define CLKG_PERIPH_RATIO_RESET 5'h01
`define CLKG_MEM_RATIO_RESET    5'h01
`define CLKG_AUX_RATIO_RESET    5'h07

`define CLKG_GBL_PERIPH_OUT_EN_BIT 3
`define CLKG_GBL_MEM_OUT_EN_BIT    5
`define CLKG_CFG_MEM_SRC_BIT       4

`define CLKG_OSC_STABLE_TICKS 16'h1000

`endif

// [rtl/clkg_controller.sv]
// clock generator controller: registers, reference select, dividers and clock pins
`timescale 1ns/10ps
`include "clkg_consts.svh"
module clkg_controller
   import clkg_pkg::*;
#(
   parameter logic [15:0] OSC_STABLE_TICKS = `CLKG_OSC_STABLE_TICKS
)
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [31:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_wdata,
   output logic [31:0]      reg_rdata,
   input  wire logic        ref_tick,
   input  wire logic        pll_out_tick,
   input  wire logic        mem_clock_in_pin,
   input  wire logic [31:0] device_config_reg,
   input  wire logic [31:0] mem_global_control,
   output logic             pll_ref_tick,
   output logic             pll_reset_ctl,
   output logic             pll_power_down,
   output logic [4:0]       pll_multiplier,
   output logic             core_clock,
   output logic             periph_bus_clock,
   output logic             mem_iface_clock,
   output logic             periph_clock_pin,
   output logic             aux_clock_pin,
   output logic             mem_clock_out_pin
);
   typedef struct packed {
      logic                                 pll_select;
      logic                                 sel_active;
      logic                                 pll_power_down;
      logic                                 pll_reset_ctl;
      clkg_ratio_t                          mult;
      logic [CLKG_NUM_DIV-1:0]              div_en;
      logic [CLKG_NUM_DIV-1:0][4:0]         div_ratio;
      logic                                 stable;
      logic [15:0]                          osc_cnt;
      logic [31:0]                          rdata;
      logic                                 periph_pin;
      logic                                 aux_pin;
      logic                                 mem_pin;
   } clkg_ctl_state_t;

   localparam logic [CLKG_NUM_DIV-1:0][4:0] RATIO_RESET = {
      `CLKG_AUX_RATIO_RESET, `CLKG_MEM_RATIO_RESET, `CLKG_PERIPH_RATIO_RESET,
      `CLKG_CORE_RATIO_RESET, `CLKG_PRE_RATIO_RESET};

   clkg_ctl_state_t st;
   clkg_ctl_state_t next_st;
   logic            hf_tick;
   logic [CLKG_NUM_DIV-1:0] div_tick;

   clkg_div_if dif [CLKG_NUM_DIV] ();

   // selected high-frequency reference
   assign hf_tick = st.sel_active ? pll_out_tick : ref_tick;

   // one divider each: prescaler, core, peripheral, memory, auxiliary
   generate
      for (genvar i = 0; i < CLKG_NUM_DIV; i++) begin : g_div
         // prescaler and auxiliary divide the raw input, the rest the reference
         assign dif[i].in_tick = (i == int'(CLKG_DIV_PRE) || i == int'(CLKG_DIV_AUX)) ? ref_tick : hf_tick;
         assign dif[i].enable  = st.div_en[i];
         assign dif[i].ratio   = st.div_ratio[i];
         assign div_tick[i]    = dif[i].out_tick;
         clkg_divider u_div (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .dif      (dif[i])
         );
      end
   endgenerate

   function automatic logic [31:0] div_word(input logic en, input logic [4:0] r);
      div_word = {16'h0000, en, 10'h000, r};
   endfunction : div_word

   always_comb begin
      logic [2:0] widx;
      logic       wsel;
      next_st       = st;
      widx          = 3'h0;
      wsel          = 1'b0;
      next_st.rdata = 32'h0000_0000;

      // oscillator settle counter on input ticks
      if (!st.stable && ref_tick) begin
         if (st.osc_cnt >= OSC_STABLE_TICKS - 16'h0001) begin
            next_st.stable = 1'b1;
         end else begin
            next_st.osc_cnt = st.osc_cnt + 16'h0001;
         end
      end

      // select changes only on an input tick, so no half period is cut
      if (ref_tick) begin
         next_st.sel_active = st.pll_select;
      end

      unique case (reg_addr)
         `CLKG_ADDR_PRE_DIV:    begin widx = 3'(CLKG_DIV_PRE);    wsel = 1'b1; end
         `CLKG_ADDR_CORE_DIV:   begin widx = 3'(CLKG_DIV_CORE);   wsel = 1'b1; end
         `CLKG_ADDR_PERIPH_DIV: begin widx = 3'(CLKG_DIV_PERIPH); wsel = 1'b1; end
         `CLKG_ADDR_MEM_DIV:    begin widx = 3'(CLKG_DIV_MEM);    wsel = 1'b1; end
         `CLKG_ADDR_AUX_DIV:    begin widx = 3'(CLKG_DIV_AUX);    wsel = 1'b1; end
         default:               begin widx = 3'h0;                wsel = 1'b0; end
      endcase

      if (reg_wr) begin
         if (reg_addr == `CLKG_ADDR_CSR) begin
            // only bits 3, 1, 0 are writable; reserved and stable ignore writes
            next_st.pll_select     = reg_wdata[`CLKG_CSR_SELECT_BIT];
            next_st.pll_power_down = reg_wdata[`CLKG_CSR_PWRDN_BIT];
            next_st.pll_reset_ctl  = reg_wdata[`CLKG_CSR_RESET_BIT];
         end else if (reg_addr == `CLKG_ADDR_MULT) begin
            // reserved multiplier codes are refused, old value kept
            if (reg_wdata[4:0] >= `CLKG_MULT_MIN) begin
               next_st.mult = reg_wdata[4:0];
            end
         end else if (wsel) begin
            next_st.div_en[widx]    = reg_wdata[`CLKG_DIV_EN_BIT];
            next_st.div_ratio[widx] = reg_wdata[`CLKG_DIV_RATIO_MSB:0];
         end
      end

      if (reg_rd) begin
         if (reg_addr == `CLKG_ADDR_CSR) begin
            next_st.rdata[`CLKG_CSR_SELECT_BIT] = st.pll_select;
            next_st.rdata[`CLKG_CSR_PWRDN_BIT]  = st.pll_power_down;
            next_st.rdata[`CLKG_CSR_RESET_BIT]  = st.pll_reset_ctl;
            next_st.rdata[`CLKG_CSR_STABLE_BIT] = st.stable;
         end else if (reg_addr == `CLKG_ADDR_MULT) begin
            next_st.rdata = {27'h000_0000, st.mult};
         end else if (wsel) begin
            next_st.rdata = div_word(st.div_en[widx], st.div_ratio[widx]);
         end
      end

      // peripheral pin: peripheral clock when both enables set
      next_st.periph_pin = div_tick[CLKG_DIV_PERIPH] & st.div_en[CLKG_DIV_PERIPH]
                           & mem_global_control[`CLKG_GBL_PERIPH_OUT_EN_BIT];
      // auxiliary pin straight from the input path, never through the pll
      next_st.aux_pin = div_tick[CLKG_DIV_AUX] & st.div_en[CLKG_DIV_AUX];
      // memory pin: internal memory clock or external input, gated by enable
      next_st.mem_pin = mem_global_control[`CLKG_GBL_MEM_OUT_EN_BIT]
                        & (device_config_reg[`CLKG_CFG_MEM_SRC_BIT] ? mem_clock_in_pin
                                                                  : div_tick[CLKG_DIV_MEM]);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st                <= '0;
         st.pll_reset_ctl  <= 1'b1;
         st.pll_power_down <= 1'b0;
         st.pll_select     <= 1'b0;
         st.mult           <= `CLKG_MULT_RESET;
         st.div_en         <= '1;
         st.div_ratio      <= RATIO_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata         = st.rdata;
   assign pll_ref_tick      = div_tick[CLKG_DIV_PRE];
   assign pll_reset_ctl     = st.pll_reset_ctl;
   assign pll_power_down    = st.pll_power_down;
   assign pll_multiplier    = st.mult;
   assign core_clock        = div_tick[CLKG_DIV_CORE];
   assign periph_bus_clock  = div_tick[CLKG_DIV_PERIPH];
   assign mem_iface_clock   = div_tick[CLKG_DIV_MEM];
   assign periph_clock_pin  = st.periph_pin;
   assign aux_clock_pin     = st.aux_pin;
   assign mem_clock_out_pin = st.mem_pin;
endmodule : clkg_controller

// [rtl/clkg_div_if.sv]
// control and tick signals between the controller and one divider
`timescale 1ns/10ps
interface clkg_div_if;
   import clkg_pkg::*;
   logic        in_tick;
   logic        enable;
   clkg_ratio_t ratio;
   logic        out_tick;
   modport ctl (output in_tick, output enable, output ratio, input out_tick);
   modport div (input in_tick, input enable, input ratio, output out_tick);
endinterface : clkg_div_if

// [rtl/clkg_divider.sv]
// one programmable divider of a tick stream, ratio code n divides by n+1
`timescale 1ns/10ps
module clkg_divider
   import clkg_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst_n,
   clkg_div_if.div   dif
);
   clkg_div_state_t st;
   clkg_div_state_t next_st;

   always_comb begin
      next_st          = st;
      next_st.out_tick = 1'b0;
      if (!dif.enable) begin
         // disabled divider stays silent and restarts cleanly
         next_st.count     = 5'h0_0;
         next_st.cur_ratio = dif.ratio;
      end else if (dif.in_tick) begin
         if (st.count >= st.cur_ratio) begin
            next_st.count     = 5'h0_0;
            next_st.out_tick  = 1'b1;
            // new ratio taken only at a period boundary, no short period
            next_st.cur_ratio = dif.ratio;
         end else begin
            next_st.count = st.count + 5'h0_1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dif.out_tick = st.out_tick;
endmodule : clkg_divider

// [rtl/clkg_pkg.sv]
// types shared by the clock generator modules
package clkg_pkg;
   typedef enum logic [2:0] {
      CLKG_DIV_PRE,
      CLKG_DIV_CORE,
      CLKG_DIV_PERIPH,
      CLKG_DIV_MEM,
      CLKG_DIV_AUX
   } clkg_div_idx_t;

   localparam int CLKG_NUM_DIV = 5;

   typedef logic [4:0] clkg_ratio_t;

   typedef struct packed {
      clkg_ratio_t cur_ratio;
      clkg_ratio_t count;
      logic        out_tick;
   } clkg_div_state_t;
endpackage : clkg_pkg

// [tb/clkg_controller_props.sv]
// port assertions of the clock generator controller
`timescale 1ns/10ps
`include "clkg_consts.svh"
module clkg_controller_props (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [31:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        mem_clock_in_pin,
   input wire logic [31:0] device_config_reg,
   input wire logic [31:0] mem_global_control,
   input wire logic        pll_reset_ctl,
   input wire logic        pll_power_down,
   input wire logic [4:0]  pll_multiplier,
   input wire logic        core_clock,
   input wire logic        periph_bus_clock,
   input wire logic        mem_iface_clock,
   input wire logic        periph_clock_pin,
   input wire logic        mem_clock_out_pin
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire csr_wr = reg_wr && reg_addr == `CLKG_ADDR_CSR;
   wire mul_wr = reg_wr && reg_addr == `CLKG_ADDR_MULT;
   AST_RESET_CTL:
      assert property (csr_wr |=> pll_reset_ctl == $past(reg_wdata[3])) else $error("pll reset bit wrong");
   AST_POWER_DOWN:
      assert property (csr_wr |=> pll_power_down == $past(reg_wdata[1])) else $error("power down bit wrong");
   AST_MULT_TAKE:
      assert property (mul_wr && reg_wdata[4:0] >= 5'h04 |=> pll_multiplier == $past(reg_wdata[4:0]))
         else $error("multiplier not taken");
   AST_MULT_REFUSE:
      assert property (mul_wr && reg_wdata[4:0] < 5'h04 |=> $stable(pll_multiplier)) else $error("reserved code taken");
   AST_CSR_RSVD:
      assert property (reg_rd && reg_addr == `CLKG_ADDR_CSR |=> reg_rdata[31:7] == '0 && reg_rdata[5:4] == 2'h0)
         else $error("reserved bits not zero");
   AST_PERIPH_SRC:
      assert property (periph_clock_pin |-> $past(periph_bus_clock)) else $error("periph pin without clock");
   AST_PERIPH_GATE:
      assert property (!mem_global_control[3] ##1 !mem_global_control[3] |-> !periph_clock_pin)
         else $error("periph pin not gated");
   AST_MEM_GATE:
      assert property (!mem_global_control[5] ##1 !mem_global_control[5] |-> !mem_clock_out_pin)
         else $error("mem pin not gated");
   AST_MEM_INT:
      assert property (mem_clock_out_pin && !$past(device_config_reg[4]) |-> $past(mem_iface_clock))
         else $error("mem pin without clock");
   AST_MEM_EXT:
      assert property ($past(device_config_reg[4]) && $past(mem_global_control[5])
         |-> mem_clock_out_pin == $past(mem_clock_in_pin)) else $error("mem pin not external");
   cover property (core_clock);
   cover property (mem_clock_out_pin && device_config_reg[4]);
   cover property (mul_wr && reg_wdata[4:0] < 5'h04);
endmodule : clkg_controller_props

// [tb/test_clkg_controller.sv]
// self-checking bench of the clock generator controller
`timescale 1ns/10ps
`include "clkg_consts.svh"
module test_clkg_controller;
   import clkg_pkg::*;
   logic        core_clk           = 1'b0;
   logic        rst_n              = 1'b0;
   logic [31:0] reg_addr           = 32'h0000_0000;
   logic        reg_wr             = 1'b0;
   logic        reg_rd             = 1'b0;
   logic [31:0] reg_wdata          = 32'h0000_0000;
   logic [1:0]  ph                 = 2'h0;
   logic        pll_out_tick       = 1'b1;
   logic [31:0] device_config_reg  = 32'h0000_0000;
   logic [31:0] mem_global_control = 32'h0000_0028;
   wire         ref_tick           = ph[0];
   wire         mem_clock_in_pin   = ph[1];
   logic [31:0] reg_rdata;
   logic [4:0]  pll_multiplier;
   logic        pll_ref_tick, pll_reset_ctl, pll_power_down, core_clock, periph_bus_clock;
   logic        mem_iface_clock, periph_clock_pin, aux_clock_pin, mem_clock_out_pin;
   wire  [4:0]  clks = {pll_ref_tick, aux_clock_pin, mem_iface_clock, periph_bus_clock, core_clock};
   logic [31:0] mdl [8] = '{32'h0000_0008, 32'h0000_0007, 32'h0000_8000, 32'h0000_8000,
                            32'h0000_8001, 32'h0000_8001, 32'h0000_8007, 32'h0000_0000};
   int          err_count = 0;
   int          n_checks  = 0;
   int          seed      = 32'h6c99_f03a;
   int          d, e, cd, n;
   logic        ext_lvl;

   // short stable count keeps the run brief
   clkg_controller #(.OSC_STABLE_TICKS(16'h0008)) dut_u (.*);

   initial begin
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) ph <= #1 ph + 2'h1;

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [31:0] adr(input int i);
      return (i == 0) ? `CLKG_ADDR_CSR : `CLKG_ADDR_MULT + 32'(4 * (i - 1));
   endfunction : adr

   // a spare edge after each strobe so no strobe is set twice in one step
   task automatic wr(input int i, input logic [31:0] v);
      reg_addr  = adr(i);
      reg_wdata = v;
      reg_wr    = 1'b1;
      @(posedge core_clk) #1;
      reg_wr    = 1'b0;
      if (i == 1) begin
         if (v[4:0] >= `CLKG_MULT_MIN) mdl[1] = {27'h000_0000, v[4:0]};
      end else if (i == 0) mdl[0] = (v & 32'h0000_000b) | (mdl[0] & 32'h0000_0040);
      else if (i < 7) mdl[i] = v & 32'h0000_801f;
      @(posedge core_clk) #1;
   endtask : wr

   task automatic rd(input int i);
      reg_addr = adr(i);
      reg_rd   = 1'b1;
      @(posedge core_clk) #1;
      check(reg_rdata, mdl[i]);
      reg_rd   = 1'b0;
      @(posedge core_clk) #1;
   endtask : rd

   // spacing of the last two of three pulses, so old ratios have drained
   task automatic gap(input int s, input int x);
      int p;
      int q;
      int c;
      p = 0;
      q = 0;
      c = 0;
      for (int t = 0; t < 400 && c < 3; t++) begin
         @(posedge core_clk) #1;
         if (clks[s] === 1'b1) begin
            q = t - p;
            p = t;
            c++;
         end
      end
      if (c < 3) begin
         err_count++;
         tally_and_finish();
      end
      check(q, x);
   endtask : gap

   initial begin
      repeat (5) @(posedge core_clk);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 8; i++) rd(i);
      repeat (20) @(posedge core_clk);
      #1 mdl[0][6] = 1'b1;
      rd(0);
      for (int k = 0; k < 16; k++) begin
         // core and peripheral enables forced on, random otherwise
         wr(k % 8, $random(seed) | ((k % 8 == 3 || k % 8 == 4) ? 32'h0000_8000 : 32'h0000_0000));
         rd(k % 8);
         check({pll_reset_ctl, pll_power_down}, {mdl[0][3], mdl[0][1]});
         check(pll_multiplier, mdl[1][4:0]);
      end
      for (int m = 0; m < 32; m += 3) begin
         wr(1, m);
         rd(1);
      end
      cd = 0;
      for (int r = 0; r < 2; r++) begin
         // bypass with the pll held in reset before its input changes
         wr(0, 32'h0000_0008);
         d = $random(seed) & 3;
         e = $random(seed) & 3;
         if (d < cd) wr(3, 32'h0000_8000 | d);
         wr(4, 32'h0000_8001 | (d << 1));
         wr(3, 32'h0000_8000 | d);
         cd = d;
         wr(2, 32'h0000_8000 | e);
         wr(5, 32'h0000_8000 | e);
         wr(6, 32'h0000_8000 | e);
         // reset has stood ten cycles or more by now
         wr(0, 32'h0000_0000);
         // worst-case lock time spent in bypass before the pll path
         repeat (9375) @(posedge core_clk);
         #1 wr(0, r);
         for (int s = 0; s < 4 + r; s++)
            gap(s, (s > 2 || r == 0 ? 2 : 1) * (s == 1 ? 2 * d + 2 : s == 0 ? d + 1 : e + 1));
      end
      // memory divider off only while the external memory clock is in use
      wr(5, 32'h0000_0002);
      device_config_reg  = 32'h0000_0010;
      mem_global_control = 32'h0000_0020;
      n = 0;
      repeat (40) begin
         @(posedge core_clk);
         ext_lvl = mem_clock_in_pin;
         #1 n += (mem_iface_clock !== 1'b0) + (periph_clock_pin !== 1'b0);
         check(mem_clock_out_pin, ext_lvl);
      end
      mem_global_control = 32'h0000_0000;
      repeat (8) begin
         @(posedge core_clk) #1;
         n += (mem_clock_out_pin !== 1'b0);
      end
      check(n, 0);
      tally_and_finish();
   end
endmodule : test_clkg_controller

bind clkg_controller clkg_controller_props chk_u (.*);
